/* pkg/wrc_consts.svh */
// Constants of the watchdog and reset controller: offsets, fields,
// reset values and timing counts. Definitions only.
`ifndef WRC_CONSTS_SVH
`define WRC_CONSTS_SVH
// ****************************************
// Register offsets (8-bit byte addresses)
// ****************************************
`define WRC_OFF_CAUSE      8'h00
`define WRC_OFF_OPT1       8'h01
`define WRC_OFF_OPT2       8'h02
`define WRC_OFF_ISTAT      8'h03
`define WRC_OFF_IMASK      8'h04
`define WRC_OFF_WCNT       8'h05
// ****************************************
// Field positions
// ****************************************
`define WRC_OPT1_EN_BIT    7
`define WRC_OPT1_TMO_BIT   6
`define WRC_OPT2_CLK_BIT   7
`define WRC_CAUSE_POR_BIT  7
`define WRC_CAUSE_PIN_BIT  6
`define WRC_CAUSE_WDG_BIT  5
`define WRC_CAUSE_ILLEGAL_OPCODE_RESET_BIT 4
`define WRC_CAUSE_ILLEGAL_ADDRESS_RESET_BIT 3
`define WRC_CAUSE_LVD_BIT  1
`define WRC_EVT_HALF_BIT   0
`define WRC_EVT_LOCK_BIT   1
// ****************************************
// Reset values
// ****************************************
`define WRC_OPT1_RST       8'hC0
`define WRC_OPT2_RST       8'h00
`define WRC_CAUSE_POR      8'h80
`define WRC_VEC_HI_ADDR    16'hFFFE
`define WRC_VEC_LO_ADDR    16'hFFFF
`define WRC_SP_RST         16'h00FF
// ****************************************
// Timing: slow watchdog tick of 1 ms at 100 MHz
// ****************************************
`define WRC_LPO_PERIOD_NS  1000000
`define WRC_CLK_PERIOD_NS  10
`define WRC_LPO_CYCLES     (`WRC_LPO_PERIOD_NS / `WRC_CLK_PERIOD_NS)
`define WRC_LPO_SHORT_LOG2 5
`define WRC_LPO_LONG_LOG2  8
`define WRC_BUS_SHORT_LOG2 13
`define WRC_BUS_LONG_LOG2  18
`endif

/* pkg/wrc_pkg.sv */
// Types shared by the watchdog and reset controller files.
// Assumes the constants header is compiled alongside.
package wrc_pkg;
  // Register port request, one cycle per access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wrc_bus_req_t;
  // Reset requests from the rest of the chip, active high levels
  typedef struct packed {
    logic pin;
    logic illegal_opcode_reset;
    logic illegal_address_reset;
    logic low_voltage_reset;
    logic dbg;
  } wrc_rst_src_t;
  // Reset sequencer states, one-hot
  typedef enum logic [4:0] {
    WRC_ST_HOLD = 5'b00001,
    WRC_ST_VHI  = 5'b00010,
    WRC_ST_VLO  = 5'b00100,
    WRC_ST_LOAD = 5'b01000,
    WRC_ST_RUN  = 5'b10000
  } wrc_state_t;
endpackage

/* rtl/wrc_wdog_counter.sv */
// Watchdog counter with selectable overflow count.
// Assumes tick and clear come from the controller on sys_clk_in.
`timescale 1ns/100ps
`include "wrc_consts.svh"
module wrc_wdog_counter (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clr_in,     // Synchronous clear
  input  wire logic        tick_in,    // Count enable pulse
  input  wire logic        clk_sel_in, // 1 bus clock, 0 slow tick
  input  wire logic        tmo_sel_in, // 1 long, 0 short
  output logic      [17:0] count_out,
  output logic             ovf_out,    // Overflow this cycle
  output logic             half_out    // Half way this cycle
);
  logic [17:0] limit_m1; // Last count before overflow
  logic [4:0]  lg;       // Log2 of overflow count

  // ****************************************
  // Overflow count select
  // ****************************************
  always_comb begin
    unique case ({clk_sel_in, tmo_sel_in})
      2'b00:   lg = 5'(`WRC_LPO_SHORT_LOG2);
      2'b01:   lg = 5'(`WRC_LPO_LONG_LOG2);
      2'b10:   lg = 5'(`WRC_BUS_SHORT_LOG2);
      default: lg = 5'(`WRC_BUS_LONG_LOG2);
    endcase
    limit_m1 = 18'((19'h00001 << lg) - 19'h00001);
  end

  assign ovf_out  = tick_in && (count_out == limit_m1);
  assign half_out = tick_in && (count_out == (limit_m1 >> 1));

  // Counter; clear wins over a tick in the same cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out <= 18'h00000;
    end else if (clr_in || ovf_out) begin
      count_out <= 18'h00000;
    end else if (tick_in) begin
      count_out <= count_out + 18'h00001;
    end
  end
endmodule // wrc_wdog_counter

/* rtl/wrc_top.sv */
// Reset control with watchdog: reset sequencing, reset cause record,
// write-once option registers, watchdog and interrupt status.
// Assumes a one-clock register port and a memory read port whose data
// returns one cycle after the read strobe.
`timescale 1ns/100ps
`include "wrc_consts.svh"
module wrc_top #(
  parameter int LPO_DIV = `WRC_LPO_CYCLES // Bus cycles per slow tick
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,    // Power-on reset
  input  wire wrc_pkg::wrc_bus_req_t bus_in,
  output logic               [7:0]  rdata_out,
  input  wire wrc_pkg::wrc_rst_src_t src_in,
  input  wire logic                 stop_in,     // Stop mode
  input  wire logic                 debug_in,    // Background debug
  output logic              [15:0]  mem_addr_out,
  output logic                      mem_rd_out,
  input  wire logic          [7:0]  mem_rdata_in,
  output logic                      sys_reset_out,
  output logic                      pc_load_out,
  output logic              [15:0]  pc_out,
  output logic              [15:0]  sp_out,
  output logic                      imask_set_out,
  output logic                      periph_en_out,
  output logic                      pin_hiz_out,
  output logic                      pullup_en_out,
  output logic                      irq_out
);
  // ****************************************
  // Declarations
  // ****************************************
  wrc_pkg::wrc_state_t state_reg;   // Sequencer state
  logic [7:0]  cause_reg;           // Reset cause record
  logic [7:0]  opt1_reg;            // Enable and timeout select
  logic [7:0]  opt2_reg;            // Clock select
  logic        opt1_lock_reg;       // Option one written once
  logic        opt2_lock_reg;       // Option two written once
  logic [7:0]  istat_reg;           // Sticky event bits
  logic [7:0]  imask_reg;           // Event mask
  logic [16:0] lpo_div_reg;         // Slow tick divider
  logic        lpo_tick;            // One-cycle slow tick
  logic        stop_q_reg;          // Stop mode last cycle
  logic [17:0] wcnt;                // Watchdog count
  logic        ovf;                 // Watchdog overflow
  logic        half;                // Watchdog half way
  logic        wd_en;               // Watchdog enabled
  logic        wd_tick;             // Counter advance
  logic        wd_clr;              // Counter clear
  logic        run;                 // Sequencer in run
  logic        src_any;             // Any reset request
  logic        go_reset;            // Start a system reset
  logic        wr_opt1_first;       // Accepted option one write
  logic        wr_opt2_first;       // Accepted option two write
  logic        wr_rejected;         // Write to a locked option
  logic [7:0]  evt;                 // Events into status

  // Register address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign run     = (state_reg == wrc_pkg::WRC_ST_RUN);
  assign src_any = src_in.pin | src_in.illegal_opcode_reset | src_in.illegal_address_reset |
                   src_in.low_voltage_reset | src_in.dbg;
  assign wd_en   = opt1_reg[`WRC_OPT1_EN_BIT];
  assign go_reset = run && (src_any || (ovf && wd_en));

  // ****************************************
  // Reset sequencer
  // ****************************************
  // Holds reset while a request stays active, then fetches the vector
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= wrc_pkg::WRC_ST_HOLD;
    end else begin
      unique case (state_reg)
        wrc_pkg::WRC_ST_HOLD: begin
          if (!src_any) begin
            state_reg <= wrc_pkg::WRC_ST_VHI;
          end
        end
        wrc_pkg::WRC_ST_VHI:  state_reg <= wrc_pkg::WRC_ST_VLO;
        wrc_pkg::WRC_ST_VLO:  state_reg <= wrc_pkg::WRC_ST_LOAD;
        wrc_pkg::WRC_ST_LOAD: state_reg <= wrc_pkg::WRC_ST_RUN;
        wrc_pkg::WRC_ST_RUN: begin
          if (go_reset) begin
            state_reg <= wrc_pkg::WRC_ST_HOLD;
          end
        end
      endcase
    end
  end

  always_comb begin
    mem_rd_out   = 1'b0;
    mem_addr_out = 16'h0000;
    if (state_reg == wrc_pkg::WRC_ST_VHI) begin
      mem_rd_out   = 1'b1;
      mem_addr_out = `WRC_VEC_HI_ADDR;
    end else if (state_reg == wrc_pkg::WRC_ST_VLO) begin
      mem_rd_out   = 1'b1;
      mem_addr_out = `WRC_VEC_LO_ADDR;
    end
  end

  // Vector bytes land one cycle after each read
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_out      <= 16'h0000;
      pc_load_out <= 1'b0;
    end else begin
      pc_load_out <= (state_reg == wrc_pkg::WRC_ST_LOAD);
      if (state_reg == wrc_pkg::WRC_ST_VLO) begin
        pc_out[15:8] <= mem_rdata_in;
      end
      if (state_reg == wrc_pkg::WRC_ST_LOAD) begin
        pc_out[7:0] <= mem_rdata_in;
      end
    end
  end

  // ****************************************
  // Reset-time outputs to the core and pads
  // ****************************************
  // Registered so they are clean from reset onward
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_reset_out <= 1'b1;
      sp_out        <= `WRC_SP_RST;
      imask_set_out <= 1'b1;
      periph_en_out <= 1'b0;
      pin_hiz_out   <= 1'b1;
      pullup_en_out <= 1'b0;
    end else begin
      sys_reset_out <= !run || go_reset;
      sp_out        <= `WRC_SP_RST;
      imask_set_out <= !run || go_reset;
      periph_en_out <= run && !go_reset;
      pin_hiz_out   <= !run || go_reset;
      pullup_en_out <= 1'b0;
    end
  end

  // ****************************************
  // Reset cause record
  // ****************************************
  // Debug-forced reset leaves every bit clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cause_reg <= `WRC_CAUSE_POR;
    end else if (go_reset) begin
      cause_reg <= 8'h00;
      cause_reg[`WRC_CAUSE_PIN_BIT]  <= src_in.pin;
      cause_reg[`WRC_CAUSE_WDG_BIT]  <= ovf && wd_en;
      cause_reg[`WRC_CAUSE_ILLEGAL_OPCODE_RESET_BIT] <= src_in.illegal_opcode_reset;
      cause_reg[`WRC_CAUSE_ILLEGAL_ADDRESS_RESET_BIT] <= src_in.illegal_address_reset;
      cause_reg[`WRC_CAUSE_LVD_BIT]  <= src_in.low_voltage_reset;
    end
  end

  // ****************************************
  // Write-once option registers
  // ****************************************
  assign wr_opt1_first = run && bus_in.wr && !opt1_lock_reg &&
                         hit(bus_in.addr, `WRC_OFF_OPT1);
  assign wr_opt2_first = run && bus_in.wr && !opt2_lock_reg &&
                         hit(bus_in.addr, `WRC_OFF_OPT2);
  assign wr_rejected   = run && bus_in.wr &&
                         ((opt1_lock_reg && hit(bus_in.addr, `WRC_OFF_OPT1))
                       || (opt2_lock_reg && hit(bus_in.addr, `WRC_OFF_OPT2)));

  // Lock protects a lost program from changing the watchdog
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      opt1_reg      <= `WRC_OPT1_RST;
      opt2_reg      <= `WRC_OPT2_RST;
      opt1_lock_reg <= 1'b0;
      opt2_lock_reg <= 1'b0;
    end else if (!run || go_reset) begin
      opt1_reg      <= `WRC_OPT1_RST;
      opt2_reg      <= `WRC_OPT2_RST;
      opt1_lock_reg <= 1'b0;
      opt2_lock_reg <= 1'b0;
    end else begin
      if (wr_opt1_first) begin
        opt1_reg      <= bus_in.wdata &
                         ((8'h01 << `WRC_OPT1_EN_BIT) |
                          (8'h01 << `WRC_OPT1_TMO_BIT));
        opt1_lock_reg <= 1'b1;
      end
      if (wr_opt2_first) begin
        opt2_reg      <= bus_in.wdata & (8'h01 << `WRC_OPT2_CLK_BIT);
        opt2_lock_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Slow tick divider and stop tracking
  // ****************************************
  assign lpo_tick = (lpo_div_reg == 17'(LPO_DIV - 1));

  // Free-running so the slow tick keeps its period across system resets
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lpo_div_reg <= 17'h00000;
      stop_q_reg  <= 1'b0;
    end else begin
      lpo_div_reg <= lpo_tick ? 17'h00000 : lpo_div_reg + 17'h00001;
      stop_q_reg  <= stop_in;
    end
  end

  // ****************************************
  // Watchdog counter control
  // ****************************************
  always_comb begin
    // clock select: bus or slow tick
    wd_tick = run && wd_en &&
              (opt2_reg[`WRC_OPT2_CLK_BIT] ? 1'b1 : lpo_tick);
    // debug holds; bus clock frozen in stop
    if (debug_in || stop_in) begin
      wd_tick = 1'b0;
    end
    wd_clr = !run || go_reset;
    // any write to cause address services
    if (run && bus_in.wr && hit(bus_in.addr, `WRC_OFF_CAUSE)) begin
      wd_clr = 1'b1;
    end
    if (wr_opt1_first || wr_opt2_first) begin
      wd_clr = 1'b1;
    end
    // slow tick: held at zero while in stop
    if (stop_in && !opt2_reg[`WRC_OPT2_CLK_BIT]) begin
      wd_clr = 1'b1;
    end
  end

  wrc_wdog_counter u_cnt (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .clr_in     (wd_clr),
    .tick_in    (wd_tick),
    .clk_sel_in (opt2_reg[`WRC_OPT2_CLK_BIT]),
    .tmo_sel_in (opt1_reg[`WRC_OPT1_TMO_BIT]),
    .count_out  (wcnt),
    .ovf_out    (ovf),
    .half_out   (half)
  );

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  always_comb begin
    evt = 8'h00;
    evt[`WRC_EVT_HALF_BIT] = half && !wd_clr;
    evt[`WRC_EVT_LOCK_BIT] = wr_rejected;
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      istat_reg <= 8'h00;
      imask_reg <= 8'h00;
    end else if (!run || go_reset) begin
      istat_reg <= 8'h00;
      imask_reg <= 8'h00;
    end else begin
      if (bus_in.wr && hit(bus_in.addr, `WRC_OFF_ISTAT)) begin
        istat_reg <= (istat_reg & ~bus_in.wdata) | evt;
      end else begin
        istat_reg <= istat_reg | evt;
      end
      if (bus_in.wr && hit(bus_in.addr, `WRC_OFF_IMASK)) begin
        imask_reg <= bus_in.wdata;
      end
    end
  end

  assign irq_out = |(istat_reg & imask_reg);

  // ****************************************
  // Register read port
  // ****************************************
  // Data stand one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      unique case (bus_in.addr)
        `WRC_OFF_CAUSE: rdata_out <= cause_reg;
        `WRC_OFF_OPT1:  rdata_out <= opt1_reg;
        `WRC_OFF_OPT2:  rdata_out <= opt2_reg;
        `WRC_OFF_ISTAT: rdata_out <= istat_reg;
        `WRC_OFF_IMASK: rdata_out <= imask_reg;
        `WRC_OFF_WCNT:  rdata_out <= wcnt[7:0];
        default:        rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_vec_order: assert property (
    state_reg == wrc_pkg::WRC_ST_VHI |->
      mem_addr_out == `WRC_VEC_HI_ADDR ##1
      mem_addr_out == `WRC_VEC_LO_ADDR ##2 pc_load_out
      && pc_out[7:0] == $past(mem_rdata_in))
    else $error("Vector fetch order wrong");
  a_sp_fixed: assert property (
    $rose(pc_load_out) |-> sp_out == `WRC_SP_RST && imask_set_out)
    else $error("Stack pointer or mask wrong at load");
  a_reset_mask: assert property (
    go_reset |=> imask_set_out && sys_reset_out)
    else $error("Mask not set on reset");
  a_pins_hiz: assert property (
    sys_reset_out |-> pin_hiz_out && !periph_en_out && !pullup_en_out)
    else $error("Pins or peripherals active in reset");
  a_cause_wdog: assert property (
    go_reset && ovf && !src_any |=>
      cause_reg == (8'h01 << `WRC_CAUSE_WDG_BIT))
    else $error("Watchdog cause not recorded");
  a_en_default: assert property (
    $rose(run) |-> wd_en && !opt2_reg[`WRC_OPT2_CLK_BIT]
                   && opt1_reg[`WRC_OPT1_TMO_BIT])
    else $error("Default options wrong after reset");
  a_dis_noreset: assert property (
    run && !wd_en && !src_any |=> run)
    else $error("Disabled watchdog caused reset");
  a_service_clr: assert property (
    run && !go_reset && bus_in.wr && hit(bus_in.addr, `WRC_OFF_CAUSE)
      |=> wcnt == 18'h00000 && $stable(cause_reg))
    else $error("Service write did not clear counter");
  a_ovf_reset: assert property (
    run && wd_en && ovf |=> !run ##1 sys_reset_out)
    else $error("Overflow did not reset");
  a_one_write: assert property (
    run && opt1_lock_reg && !go_reset |=> $stable(opt1_reg))
    else $error("Locked option register changed");
  a_debug_hold: assert property (
    debug_in && !wd_clr |=> $stable(wcnt))
    else $error("Counter moved in debug");
  a_stop_zero: assert property (
    stop_in && !opt2_reg[`WRC_OPT2_CLK_BIT] |=> wcnt == 18'h00000)
    else $error("Slow counter not zeroed in stop");

  c_wdog_reset: cover property (run && wd_en && ovf);
  c_opt_locked: cover property (wr_rejected);
  c_irq_high:   cover property ($rose(irq_out));
  c_pin_reset:  cover property (go_reset && src_in.pin);
endmodule // wrc_top

/* verification/tb_watchdog_reset_control.sv */
// Self-checking bench for the watchdog and reset controller top.
// Assumes the constants header and package are compiled first; the bench
// also plays the vector memory behind the fetch port.
`timescale 1ns/100ps
`include "wrc_consts.svh"
module tb_watchdog_reset_control;
  // ****************************************
  // Signals and bookkeeping
  // ****************************************
  logic                  sys_clk_in;    // 100 MHz clock
  logic                  rst_n_in;      // Power-on reset, active low
  wrc_pkg::wrc_bus_req_t bus_in;        // Register port request
  logic [7:0]            rdata_out;     // Register read data
  wrc_pkg::wrc_rst_src_t src_in;        // Reset requests
  logic                  stop_in;       // Stop mode level
  logic                  debug_in;      // Debug mode level
  logic [15:0]           mem_addr_out;  // Vector fetch address
  logic                  mem_rd_out;    // Vector fetch strobe
  logic [7:0]            mem_rdata_in;  // Vector memory data
  logic                  sys_reset_out, pc_load_out, imask_set_out;
  logic                  periph_en_out, pin_hiz_out, pullup_en_out, irq_out;
  logic [15:0]           pc_out, sp_out, pc_seen;
  logic [15:0]           vq[$];         // Fetch addresses seen at boot
  logic [7:0]            d, e;          // Read results
  int                    fails, cmp_count, n;

  // Short slow tick keeps the slow-clock timeouts within a quick run
  wrc_top #(.LPO_DIV(8)) DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .bus_in(bus_in), .rdata_out(rdata_out), .src_in(src_in),
    .stop_in(stop_in), .debug_in(debug_in), .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out), .mem_rdata_in(mem_rdata_in),
    .sys_reset_out(sys_reset_out), .pc_load_out(pc_load_out),
    .pc_out(pc_out), .sp_out(sp_out), .imask_set_out(imask_set_out),
    .periph_en_out(periph_en_out), .pin_hiz_out(pin_hiz_out),
    .pullup_en_out(pullup_en_out), .irq_out(irq_out));

  // ****************************************
  // Clock and vector memory
  // ****************************************
  initial sys_clk_in = 1'b0;
  always #5 sys_clk_in = ~sys_clk_in;
  // Data valid only the cycle after a strobe; toggles otherwise so a late
  // sample cannot pass by luck
  always @(posedge sys_clk_in) begin
    if (mem_rd_out) begin
      mem_rdata_in <= (mem_addr_out == 16'hFFFE) ? 8'hA5 : 8'h3C;
      vq.push_back(mem_addr_out);
    end else begin
      mem_rdata_in <= ~mem_rdata_in;
    end
    if (pc_load_out) begin
      pc_seen <= pc_out;
    end
  end

  // ****************************************
  // Compare, bus and wait tasks
  // ****************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    bus_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    bus_in.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe edge; it is taken
  // at the edge that closes that cycle, so callers resume on an edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_in);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    bus_in.rd <= 1'b0;
    @(posedge sys_clk_in);
    v = rdata_out;
  endtask
  // Bounded wait for the sequencer to leave reset
  task automatic wait_run();
    n = 0;
    while (sys_reset_out !== 1'b0 && n < 100) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk8(sys_reset_out, 1'b0);
    @(posedge sys_clk_in);
  endtask
  // Counts cycles until a watchdog reset and checks the window
  task automatic wait_bite(input int lo, input int hi);
    n = 0;
    while (sys_reset_out !== 1'b1 && n < hi + 5) begin
      @(posedge sys_clk_in);
      n++;
    end
    chk8(8'(n >= lo && n <= hi), 8'h01);
  endtask
  task automatic chk_in_reset();
    #1;
    chk8(imask_set_out, 1'b1);
    chk8(pin_hiz_out, 1'b1);
    chk8(periph_en_out, 1'b0);
    chk8(pullup_en_out, 1'b0);
    chk16(sp_out, `WRC_SP_RST);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Boot: reset outputs, vector fetch order, register defaults
  task automatic t_boot();
    chk_in_reset();
    @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    wait_run();
    chk16(16'(vq.size()), 16'h0002);
    chk16(vq[0], `WRC_VEC_HI_ADDR);
    chk16(pc_seen, 16'hA53C);
    chk8(periph_en_out, 1'b1);
    rd(`WRC_OFF_CAUSE, d); chk8(d, `WRC_CAUSE_POR);
    rd(`WRC_OFF_OPT1, d); chk8(d, 8'hC0);
    rd(`WRC_OFF_OPT2, d); chk8(d, 8'h00);
    $display("test boot done");
  endtask
  // Write-once options, refused write raises a masked interrupt
  task automatic t_lock();
    wr(`WRC_OFF_OPT2, 8'h80);
    wr(`WRC_OFF_OPT1, 8'h80);
    wr(`WRC_OFF_OPT1, 8'hC0);
    wr(`WRC_OFF_OPT2, 8'h00);
    rd(`WRC_OFF_OPT1, d); chk8(d, 8'h80);
    rd(`WRC_OFF_OPT2, d); chk8(d, 8'h80);
    chk8(irq_out, 1'b0);
    wr(`WRC_OFF_IMASK, 8'h02);
    #1 chk8(irq_out, 1'b1);
    wr(`WRC_OFF_ISTAT, 8'h02);
    #1 chk8(irq_out, 1'b0);
    $display("test lock done");
  endtask
  // Service write clears the count, hold in debug, freeze in stop
  task automatic t_hold();
    repeat (60) @(posedge sys_clk_in);
    rd(`WRC_OFF_WCNT, d);
    wr(`WRC_OFF_CAUSE, 8'h55);
    rd(`WRC_OFF_WCNT, e);
    chk8(8'(e < 8'h04 && d > 8'h30), 8'h01);
    rd(`WRC_OFF_CAUSE, d); chk8(d, `WRC_CAUSE_POR);
    debug_in <= 1'b1;
    rd(`WRC_OFF_WCNT, d);
    repeat (30) @(posedge sys_clk_in);
    rd(`WRC_OFF_WCNT, e); chk8(e, d);
    debug_in <= 1'b0;
    stop_in <= 1'b1;
    rd(`WRC_OFF_WCNT, d);
    repeat (30) @(posedge sys_clk_in);
    rd(`WRC_OFF_WCNT, e); chk8(e, d);
    stop_in <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
    rd(`WRC_OFF_WCNT, e); chk8(8'(e > d), 8'h01);
    $display("test hold done");
  endtask
  // Bus clock short timeout forces a reset after 2^13 cycles
  task automatic t_bite_bus();
    wr(`WRC_OFF_CAUSE, 8'h00);
    wait_bite(8185, 8200);
    wait_run();
    rd(`WRC_OFF_CAUSE, d); chk8(d, 8'h20);
    rd(`WRC_OFF_OPT1, d); chk8(d, 8'hC0);
    rd(`WRC_OFF_WCNT, d); chk8(8'(d < 8'h03), 8'h01);
    $display("test bite bus done");
  endtask
  // Slow tick: stop zeroes the count; short slow timeout is 2^5 ticks
  task automatic t_bite_slow();
    repeat (100) @(posedge sys_clk_in);
    rd(`WRC_OFF_WCNT, d); chk8(8'(d > 8'h08), 8'h01);
    stop_in <= 1'b1;
    repeat (20) @(posedge sys_clk_in);
    rd(`WRC_OFF_WCNT, d); chk8(d, 8'h00);
    stop_in <= 1'b0;
    repeat (24) @(posedge sys_clk_in);
    rd(`WRC_OFF_WCNT, d); chk8(8'(d < 8'h05), 8'h01);
    wr(`WRC_OFF_OPT1, 8'h80);
    rd(`WRC_OFF_WCNT, d); chk8(8'(d < 8'h02), 8'h01);
    repeat (40) @(posedge sys_clk_in);
    wr(`WRC_OFF_OPT2, 8'h00);
    wait_bite(248, 270);
    wait_run();
    $display("test bite slow done");
  endtask
  // Cleared enable never bites, even on the bus clock short setting
  task automatic t_disabled();
    wr(`WRC_OFF_OPT1, 8'h00);
    wr(`WRC_OFF_OPT2, 8'h80);
    n = 0;
    repeat (9000) begin
      @(posedge sys_clk_in);
      if (sys_reset_out !== 1'b0) begin
        n++;
      end
    end
    chk8(8'(n), 8'h00);
    $display("test disabled done");
  endtask
  // Each outside source resets and records itself; debug records nothing
  task automatic t_sources();
    logic [4:0] srcs[5];
    logic [7:0] exp[5];
    srcs = '{5'b10000, 5'b01000, 5'b00100, 5'b00010, 5'b00001};
    exp  = '{8'h40, 8'h10, 8'h08, 8'h02, 8'h00};
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk_in);
      src_in <= srcs[i];
      repeat (4) @(posedge sys_clk_in);
      chk_in_reset();
      @(posedge sys_clk_in);
      src_in <= '0;
      wait_run();
      rd(`WRC_OFF_CAUSE, d); chk8(d, exp[i]);
    end
    $display("test sources done");
  endtask

  // ****************************************
  // Verdict, watchdog and main sequence
  // ****************************************
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Tests need about 20k cycles; twice that means a hang
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
  initial begin
    rst_n_in = 1'b0;
    bus_in = '0;
    src_in = '0;
    stop_in = 1'b0;
    debug_in = 1'b0;
    mem_rdata_in = 8'h00;
    fails = 0;
    cmp_count = 0;
    repeat (16) @(posedge sys_clk_in);
    t_boot();
    t_lock();
    t_hold();
    t_bite_bus();
    t_bite_slow();
    t_disabled();
    t_sources();
    report_and_stop();
  end
endmodule // tb_watchdog_reset_control
